// ==== rtl/async_chip_select_unit.sv ====
// Four programmable chip selects with a shared cycle termination counter.
// Assumes one bus master that holds the cycle attributes only on the
// bus_start pulse and waits for bus_done; all inputs are synchronous.
//
// Contract
// - One shared termination counter, active select's waits
// - Select pins leave reset driven high, pulled up; only strap-enabled selects drive, others follow gpio_dir
// - Unconfigured select pin works as general I/O
// - User access to registers errors, changes nothing
// - Unimplemented bits drop writes without error
// - Identical registers; three reset bits from straps
// - Control registers readable and writable by supervisor only
// - Supervisor-only select ignores user accesses
// - Read-only guard select ignores write accesses
// - Width bit: 1 is 32-bit, 0 16-bit upper lanes
// - Word to 16-bit port runs two cycles
// - Extra write wait adds one, reads unchanged
// - Write mode gates lane enables to writes
// - No active select: lanes act as byte enables
// - Zero waits terminate the clock after start
// - Reads wait 0-7, writes up to 8
// - Without self termination, external acknowledge ends
// - Disabled select holds its output negated
// - At most one select; none matching, no response
// - Fixed 8 MB blocks, A[30:25] ignored, mirrored
// - External acknowledge or error ends cycle early
`timescale 1ns/100ps
module async_chip_select_unit
  import chip_select_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Reset configuration straps and chip configuration
  input  wire logic        boot_select_enable,
  input  wire logic        boot_port_width,
  input  wire logic        emul_select_enable,
  input  wire logic        emulate_internal,
  // Internal bus
  input  wire logic        bus_start,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_read,
  input  wire logic [2:0]  transfer_code,
  input  wire logic        bus_word,
  input  wire logic [3:0]  bus_byte_en,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_ready,
  output logic             bus_done,
  output logic             bus_error,
  output logic [31:0]      bus_rdata,
  // External bus
  output logic [31:0]      ext_addr,
  output logic             ext_read,
  output logic [31:0]      ext_wdata,
  input  wire logic [31:0] ext_rdata,
  output logic [3:0]       byte_lane_enable_n,
  input  wire logic        transfer_ack_n,
  input  wire logic        transfer_error_n,
  output logic             internal_term,
  // Select pins and their general-purpose use
  output logic [3:0]       select_pin_out,
  output logic [3:0]       select_pin_oe,
  input  wire logic [3:0]  select_pin_in,
  output logic [3:0]       select_pin_pullup,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_dir,
  output logic [3:0]       gpio_in
);

  // ==========================================================
  // State
  logic [15:0]           ctrl      [num_selects];
  logic [15:0]           next_ctrl [num_selects];
  bus_state_e            state,        next_state;
  logic [wait_cnt_w-1:0] count,        next_count;
  logic [wait_cnt_w-1:0] target,       next_target;
  logic                  sel_valid,    next_sel_valid;
  logic [1:0]            sel_idx,      next_sel_idx;
  logic                  split,        next_split;
  logic                  half_shift,   next_half_shift;
  logic                  cyc_read,     next_cyc_read;
  logic [3:0]            cyc_be,       next_cyc_be;
  logic [31:0]           cyc_wdata,    next_cyc_wdata;
  logic [15:0]           first_half,   next_first_half;
  logic [3:0]            select_n,     next_select_n;
  logic [31:0]           next_ext_addr;
  logic                  next_ext_read;
  logic [31:0]           next_ext_wdata;
  logic [3:0]            next_lane_n;
  logic                  next_bus_done;
  logic                  next_bus_error;
  logic [31:0]           next_bus_rdata;

  // ==========================================================
  // Decode of the cycle on the bus
  logic [3:0]  hit;
  logic        reg_hit;
  logic        ext_hit;
  logic        privileged;
  logic [1:0]  hit_idx;
  logic        hit_any;
  logic [15:0] hit_ctrl;
  logic [15:0] cur_ctrl;
  logic        half_end;
  logic        ack_seen;
  logic        err_seen;

  assign privileged = transfer_code[priv_code_bit];

  genvar g;
  generate
    for (g = 0; g < num_selects; g++) begin : gen_match
      select_match #(
        .index            (g)
      ) u_match (
        .control          (ctrl[g]),
        .emulate_internal (emulate_internal),
        .bus_addr         (bus_addr),
        .bus_read         (bus_read),
        .privileged       (privileged),
        .hit              (hit[g])
      );
    end
  endgenerate

  // Blocks are disjoint, so at most one select hits
  always_comb begin
    hit_idx = 2'h0;
    for (int i = 0; i < num_selects; i++) begin
      if (hit[i]) begin
        hit_idx = 2'(i);
      end
    end
  end

  assign hit_any  = |hit;
  assign hit_ctrl = ctrl[hit_idx];
  assign cur_ctrl = ctrl[sel_idx];
  assign reg_hit  = bus_addr[31:reg_tag_lsb]
                  == region0_select_control_offset[31:reg_tag_lsb];
  // Emulated internal block goes out only through select 1
  assign ext_hit  = bus_addr[ext_space_bit]
                  | (emulate_internal & hit[1]);

  // ==========================================================
  // Shared termination generator
  // Count 0 is the first clock after the start, hence zero waits end
  // there and each wait adds one clock
  assign internal_term = (state != st_idle) & sel_valid
                       & cur_ctrl[self_term_enable_bit]
                       & (count == target);
  assign ack_seen = ~transfer_ack_n;
  assign err_seen = ~transfer_error_n;
  assign half_end = (state != st_idle)
                  & (internal_term | ack_seen | err_seen);
  assign bus_ready = (state == st_idle);

  // ==========================================================
  // Control registers
  always_comb begin
    logic [15:0] hi_word;
    logic [15:0] lo_word;
    logic [1:0]  hi_idx;
    hi_word = 16'h0000;
    lo_word = 16'h0000;
    hi_idx  = 2'h0;
    for (int i = 0; i < num_selects; i++) begin
      next_ctrl[i] = ctrl[i];
    end
    hi_idx = {bus_addr[reg_word_bit], 1'b0};
    // Supervisor only; user writes are dropped
    if (bus_start & bus_ready & reg_hit & privileged & ~bus_read) begin
      hi_word = ctrl[hi_idx];
      lo_word = ctrl[hi_idx + 2'h1];
      if (bus_byte_en[3]) hi_word[15:8] = bus_wdata[31:24];
      if (bus_byte_en[2]) hi_word[7:0]  = bus_wdata[23:16];
      if (bus_byte_en[1]) lo_word[15:8] = bus_wdata[15:8];
      if (bus_byte_en[0]) lo_word[7:0]  = bus_wdata[7:0];
      next_ctrl[hi_idx]        = hi_word & ctrl_impl_mask;
      next_ctrl[hi_idx + 2'h1] = lo_word & ctrl_impl_mask;
    end
  end

  // Straps are taken while the synchronous reset is held
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < num_selects; i++) begin
        ctrl[i] <= ctrl_reset;
      end
      ctrl[0][select_func_enable_bit] <= boot_select_enable;
      ctrl[0][port_width_sel_bit]     <= boot_port_width;
      ctrl[1][select_func_enable_bit] <= emul_select_enable;
    end else begin
      for (int i = 0; i < num_selects; i++) begin
        ctrl[i] <= next_ctrl[i];
      end
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  always_comb begin
    logic        lane_on;
    logic        narrow;
    logic [3:0]  be_use;
    logic [31:0] rd_word;
    lane_on         = 1'b1;
    narrow          = 1'b0;
    be_use          = 4'h0;
    rd_word         = 32'h00000000;
    next_state      = state;
    next_count      = count;
    next_target     = target;
    next_sel_valid  = sel_valid;
    next_sel_idx    = sel_idx;
    next_split      = split;
    next_half_shift = half_shift;
    next_cyc_read   = cyc_read;
    next_cyc_be     = cyc_be;
    next_cyc_wdata  = cyc_wdata;
    next_first_half = first_half;
    next_select_n   = select_n;
    next_ext_addr   = ext_addr;
    next_ext_read   = ext_read;
    next_ext_wdata  = ext_wdata;
    next_lane_n     = byte_lane_enable_n;
    next_bus_done   = 1'b0;
    next_bus_error  = 1'b0;
    next_bus_rdata  = bus_rdata;
    unique case (state)
      st_idle: begin
        if (bus_start & reg_hit) begin
          next_bus_done  = 1'b1;
          next_bus_error = ~privileged;
          next_bus_rdata = bus_addr[reg_word_bit]
                         ? {ctrl[2], ctrl[3]} : {ctrl[0], ctrl[1]};
        end else if (bus_start & ext_hit) begin
          // Only a matching, enabled select takes part
          narrow          = hit_any & ~hit_ctrl[port_width_sel_bit];
          next_sel_valid  = hit_any;
          next_sel_idx    = hit_idx;
          next_split      = narrow & bus_word;
          next_half_shift = narrow & ~bus_word
                          & bus_addr[half_sel_bit];
          next_cyc_read   = bus_read;
          next_cyc_be     = bus_byte_en;
          next_cyc_wdata  = bus_wdata;
          next_target     = wait_cnt_w'(hit_ctrl[wait_state_count_msb:
                                                 wait_state_count_lsb])
                          + wait_cnt_w'(hit_ctrl[write_extra_wait_bit]
                                        & ~bus_read);
          next_count      = '0;
          next_state      = st_first;
          next_select_n   = ~(hit & {4{hit_any}});
          next_ext_addr   = bus_addr;
          next_ext_read   = bus_read;
          lane_on = ~(hit_any & hit_ctrl[write_strobe_mode_bit]
                      & bus_read);
          be_use  = bus_byte_en;
          if (narrow & bus_word) begin
            be_use         = {bus_byte_en[3:2], 2'b00};
            next_ext_wdata = {bus_wdata[31:16], 16'h0000};
          end else if (narrow & bus_addr[half_sel_bit]) begin
            be_use         = {bus_byte_en[1:0], 2'b00};
            next_ext_wdata = {bus_wdata[15:0], 16'h0000};
          end else begin
            next_ext_wdata = bus_wdata;
          end
          next_lane_n = ~(be_use & {4{lane_on}});
        end
      end
      st_first, st_second: begin
        next_count = count + wait_cnt_w'(1);
        if (half_end) begin
          rd_word = ext_rdata;
          if (split) begin
            rd_word = {first_half, ext_rdata[31:16]};
          end else if (half_shift) begin
            rd_word = {ext_rdata[31:16], ext_rdata[31:16]};
          end
          if ((state == st_first) & split & ~err_seen) begin
            // Second external cycle moves the low half
            next_first_half = ext_rdata[31:16];
            next_state      = st_second;
            next_count      = '0;
            next_ext_addr   = ext_addr + half_step;
            next_ext_wdata  = {cyc_wdata[15:0], 16'h0000};
            lane_on = ~(cur_ctrl[write_strobe_mode_bit] & cyc_read);
            next_lane_n     = ~({cyc_be[1:0], 2'b00} & {4{lane_on}});
          end else begin
            next_state     = st_idle;
            next_bus_done  = 1'b1;
            next_bus_error = err_seen;
            next_bus_rdata = rd_word;
            next_select_n  = 4'hf;
            next_lane_n    = 4'hf;
            next_sel_valid = 1'b0;
          end
        end
      end
      default: begin
        next_state    = st_idle;
        next_select_n = 4'hf;
        next_lane_n   = 4'hf;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state              <= st_idle;
      count              <= '0;
      target             <= '0;
      sel_valid          <= 1'b0;
      sel_idx            <= 2'h0;
      split              <= 1'b0;
      half_shift         <= 1'b0;
      cyc_read           <= 1'b1;
      cyc_be             <= 4'h0;
      cyc_wdata          <= 32'h00000000;
      first_half         <= 16'h0000;
      select_n           <= 4'hf;
      ext_addr           <= 32'h00000000;
      ext_read           <= 1'b1;
      ext_wdata          <= 32'h00000000;
      byte_lane_enable_n <= 4'hf;
      bus_done           <= 1'b0;
      bus_error          <= 1'b0;
      bus_rdata          <= 32'h00000000;
    end else begin
      state              <= next_state;
      count              <= next_count;
      target             <= next_target;
      sel_valid          <= next_sel_valid;
      sel_idx            <= next_sel_idx;
      split              <= next_split;
      half_shift         <= next_half_shift;
      cyc_read           <= next_cyc_read;
      cyc_be             <= next_cyc_be;
      cyc_wdata          <= next_cyc_wdata;
      first_half         <= next_first_half;
      select_n           <= next_select_n;
      ext_addr           <= next_ext_addr;
      ext_read           <= next_ext_read;
      ext_wdata          <= next_ext_wdata;
      byte_lane_enable_n <= next_lane_n;
      bus_done           <= next_bus_done;
      bus_error          <= next_bus_error;
      bus_rdata          <= next_bus_rdata;
    end
  end

  // ==========================================================
  // Pin sharing: enabled selects own the pin, others are I/O
  always_comb begin
    for (int i = 0; i < num_selects; i++) begin
      if (ctrl[i][select_func_enable_bit]) begin
        select_pin_out[i] = select_n[i];
        select_pin_oe[i]  = 1'b1;
      end else begin
        select_pin_out[i] = gpio_out[i];
        select_pin_oe[i]  = gpio_dir[i];
      end
    end
  end

  // Pull-up keeps a floating select pin negated
  assign select_pin_pullup = 4'hf;
  assign gpio_in           = select_pin_in;

endmodule // async_chip_select_unit

// ==== rtl/chip_select_pkg.sv ====
// Constants, field layout and state codes of the chip select unit.
// Assumes a 40 MHz system clock and a 32-bit internal bus.
package chip_select_pkg;

  // ==========================================================
  // Sizes
  localparam int          num_selects   = 4;
  localparam int          ctrl_w        = 16;
  localparam int          wait_cnt_w    = 4;
  localparam real         clock_mhz     = 40.0;

  // ==========================================================
  // Register map, byte addresses of each 16-bit control register
  localparam logic [31:0] region0_select_control_offset = 32'h00c20000;
  localparam logic [31:0] region1_select_control_offset = 32'h00c20002;
  localparam logic [31:0] region2_select_control_offset = 32'h00c20004;
  localparam logic [31:0] region3_select_control_offset = 32'h00c20006;
  localparam int          reg_tag_lsb   = 3;
  localparam int          reg_word_bit  = 2;

  // ==========================================================
  // Control register fields
  localparam int          supervisor_only_bit    = 15;
  localparam int          read_only_guard_bit    = 14;
  localparam int          port_width_sel_bit     = 13;
  localparam int          write_extra_wait_bit   = 12;
  localparam int          write_strobe_mode_bit  = 11;
  localparam int          wait_state_count_msb   = 10;
  localparam int          wait_state_count_lsb   = 8;
  localparam int          self_term_enable_bit   = 1;
  localparam int          select_func_enable_bit = 0;
  localparam logic [15:0] ctrl_impl_mask         = 16'hff03;
  localparam logic [15:0] ctrl_reset             = 16'h3f02;

  // ==========================================================
  // Address decode and bus attributes
  localparam int          ext_space_bit = 31;
  localparam int          block_msb     = 24;
  localparam int          block_lsb     = 23;
  localparam int          half_sel_bit  = 1;
  localparam int          priv_code_bit = 2;
  localparam logic [31:0] half_step     = 32'h00000002;

  // ==========================================================
  // Bus cycle states, Gray along idle -> first -> second
  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_first  = 2'b01,
    st_second = 2'b11
  } bus_state_e;

endpackage

// ==== rtl/select_match.sv ====
// One select's address and option match for the current bus cycle.
// Assumes address and attributes are stable while bus_start is high.
`timescale 1ns/100ps
module select_match
  import chip_select_pkg::*;
#(
  parameter int index = 0
) (
  // Select configuration
  input  wire logic [15:0] control,
  input  wire logic        emulate_internal,
  // Bus cycle attributes
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_read,
  input  wire logic        privileged,
  // Result
  output logic             hit
);

  localparam logic [1:0] block_code = index[1:0];

  logic ext_block;
  logic emul_block;
  logic priv_ok;
  logic access_ok;

  // A[30:25] are not compared, so the 32 MB region mirrors
  assign ext_block  = bus_addr[ext_space_bit]
                    & (bus_addr[block_msb:block_lsb] == block_code);
  // Select 1 may stand in for the internal block at address zero
  assign emul_block = (index == 1) & emulate_internal
                    & ~bus_addr[ext_space_bit]
                    & (bus_addr[block_msb:block_lsb] == 2'h0);
  assign priv_ok    = ~control[supervisor_only_bit] | privileged;
  assign access_ok  = ~control[read_only_guard_bit] | bus_read;

  always_comb begin
    if ((index == 1) & emulate_internal) begin
      hit = emul_block;
    end else begin
      hit = ext_block;
    end
    hit = hit & control[select_func_enable_bit] & priv_ok & access_ok;
  end

endmodule // select_match

// ==== sim/cs_chk.sv ====
// Concurrent checks on the chip select unit's top-level ports.
// Assumes one clock domain and the synchronous active-low resetn.
`timescale 1ns/100ps
module cs_chk
  import chip_select_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Internal bus
  input wire logic        bus_start,
  input wire logic [31:0] bus_addr,
  input wire logic [2:0]  transfer_code,
  input wire logic        bus_ready,
  input wire logic        bus_done,
  input wire logic        bus_error,
  input wire logic [31:0] bus_rdata,
  // External bus and pins
  input wire logic [3:0]  byte_lane_enable_n,
  input wire logic        transfer_ack_n,
  input wire logic        transfer_error_n,
  input wire logic        internal_term,
  input wire logic [3:0]  select_pin_in,
  input wire logic [3:0]  select_pin_pullup,
  input wire logic [3:0]  gpio_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Requests
  sequence reg_req;
    bus_start && bus_ready &&
      bus_addr[31:3] == region0_select_control_offset[31:3];
  endsequence
  sequence ext_req;
    bus_start && bus_ready && bus_addr[31];
  endsequence
  // ==========================================================
  // Properties
  a_reg_answer: assert property (
    reg_req ##0 transfer_code[2] |=> bus_done && !bus_error)
    else $error("supervisor register access not answered cleanly");
  a_user_error: assert property (
    reg_req ##0 !transfer_code[2] |=> bus_done && bus_error)
    else $error("user register access without transfer error");
  a_error_done: assert property (bus_error |-> bus_done)
    else $error("error without done");
  a_ext_busy: assert property (ext_req |=> !bus_ready)
    else $error("external cycle not started");
  a_done_cause: assert property (
    bus_done |-> $past(bus_start && bus_addr[31:3]
                       == region0_select_control_offset[31:3])
      || $past(internal_term) || !$past(transfer_ack_n)
      || !$past(transfer_error_n))
    else $error("cycle ended without termination");
  a_idle_lanes: assert property (
    bus_ready |-> byte_lane_enable_n == 4'hf)
    else $error("lane enables asserted while idle");
  a_rdata_hold: assert property (
    $past(resetn) && !bus_done |-> $stable(bus_rdata))
    else $error("read data changed without done");
  a_pin_pullup: assert property (select_pin_pullup == 4'hf)
    else $error("select pin pull-up missing");
  a_gpio_input: assert property (gpio_in == select_pin_in)
    else $error("general input does not follow pin");
endmodule // cs_chk

bind async_chip_select_unit cs_chk cs_chk_inst (.clock, .resetn,
  .bus_start, .bus_addr, .transfer_code, .bus_ready, .bus_done,
  .bus_error, .bus_rdata, .byte_lane_enable_n, .transfer_ack_n,
  .transfer_error_n, .internal_term, .select_pin_in, .select_pin_pullup,
  .gpio_in);

// ==== sim/ext_device_model.sv ====
// External memory model answering on the unit's external bus.
// Assumes registered unit outputs; a delay of 0 means it never answers.
`timescale 1ns/100ps
module ext_device_model (
  // Clock
  input wire logic        clock,
  // Unit side
  input wire logic [31:0] ext_addr,
  input wire logic [3:0]  lanes_n,
  input wire logic [3:0]  select_n,
  // Scenario controls
  input wire logic [3:0]  ack_delay,
  input wire logic        err_mode,
  // Answers
  output logic [31:0]     ext_rdata,
  output logic            transfer_ack_n,
  output logic            transfer_error_n
);
  // ==========================================================
  // Cycle age and answer
  logic        active;
  logic        answer;
  logic [3:0]  age   = 4'h0;
  logic [31:0] churn = 32'h0;
  assign active = !(&lanes_n) || !(&select_n);
  assign answer = active && ack_delay != 4'h0 && age + 4'h1 >= ack_delay;
  assign transfer_ack_n   = !(answer && !err_mode);
  assign transfer_error_n = !(answer && err_mode);
  // Undriven lines churn so a stale value never passes for data
  assign ext_rdata = active ? {ext_addr[15:0], ~ext_addr[15:0]}
                            : churn;
  always_ff @(posedge clock) begin
    churn <= churn + 32'h01234567;
    age   <= active ? age + 4'h1 : 4'h0;
  end
endmodule // ext_device_model

// ==== sim/async_chip_select_unit_test.sv ====
// Self-checking bench for the chip select unit with a memory model.
// Assumes 40 MHz clock; straps boot select on, 16-bit, emulation off.
`timescale 1ns/100ps
module async_chip_select_unit_test import chip_select_pkg::*;;
  logic        clock = 0, resetn = 0, bus_start = 0, bus_read = 1;
  logic        bus_word = 1, err_mode = 0, er;
  logic [31:0] bus_addr = 0, bus_wdata = 0, rd;
  logic [2:0]  transfer_code = 3'h4;
  logic [3:0]  bus_byte_en = 4'hf, gpio_out = 0, gpio_dir = 0;
  logic [3:0]  ack_delay = 0, sel, lane, pins;
  logic        bus_ready, bus_done, bus_error, ext_read, internal_term;
  logic        transfer_ack_n, transfer_error_n;
  logic [31:0] bus_rdata, ext_addr, ext_wdata, ext_rdata;
  logic [3:0]  byte_lane_enable_n, select_pin_out, select_pin_oe;
  logic [3:0]  select_pin_pullup, gpio_in;
  int          n_errors = 0, n_tests = 0, cycles = 0, nc;
  localparam logic [31:0] reg0 = region0_select_control_offset;
  // ==========================================================
  // Clock, pins and instances
  always #12.5 clock = ~clock;
  // Undriven select pins rest at the pull-up level
  assign pins = (select_pin_oe & select_pin_out) | ~select_pin_oe;
  async_chip_select_unit async_chip_select_unit_inst (.clock, .resetn,
    .boot_select_enable(1'b1), .boot_port_width(1'b0),
    .emul_select_enable(1'b0), .emulate_internal(1'b0), .bus_start,
    .bus_addr, .bus_read, .transfer_code, .bus_word, .bus_byte_en,
    .bus_wdata, .bus_ready, .bus_done, .bus_error, .bus_rdata, .ext_addr,
    .ext_read, .ext_wdata, .ext_rdata, .byte_lane_enable_n,
    .transfer_ack_n, .transfer_error_n, .internal_term, .select_pin_out,
    .select_pin_oe, .select_pin_in(pins), .select_pin_pullup, .gpio_out,
    .gpio_dir, .gpio_in);
  ext_device_model ext_device_model_inst (.clock, .ext_addr,
    .lanes_n(byte_lane_enable_n), .select_n(pins), .ack_delay, .err_mode,
    .ext_rdata, .transfer_ack_n, .transfer_error_n);
  // ==========================================================
  // Shared tasks
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One cycle; notes strobes and lanes seen low until done
  task bus(logic [31:0] a, logic r, logic [2:0] tc, logic [3:0] be,
           logic [31:0] d);
    @(posedge clock);
    bus_start <= 1;
    bus_addr <= a;
    bus_read <= r;
    transfer_code <= tc;
    bus_byte_en <= be;
    bus_wdata <= d;
    @(posedge clock);
    bus_start <= 0;
    nc = 1;
    sel = 0;
    lane = 0;
    #1;
    while (bus_done !== 1'b1 && nc < 40) begin
      sel |= ~pins;
      lane |= ~byte_lane_enable_n;
      @(posedge clock);
      #1;
      nc++;
    end
    rd = bus_rdata;
    er = bus_error;
  endtask
  task cfg(logic [1:0] k, logic [15:0] v);
    bus(reg0 | (k[1] ? 32'h4 : 32'h0), 0, 3'h4, k[0] ? 4'h3 : 4'hc, {v, v});
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    bus(reg0, 1, 3'h4, 4'hf, 0);
    check("word0", rd, 32'h1f033f02);
    bus(reg0 | 32'h4, 1, 3'h4, 4'hf, 0);
    check("word1", rd, 32'h3f023f02);
    check("idle pins", pins, 4'hf);
    @(posedge clock);
    gpio_dir <= 4'h8;
    @(posedge clock);
    #1;
    check("gpio in", gpio_in, 4'h7);
    @(posedge clock);
    gpio_dir <= 4'h0;
    $display("test reset done");
  endtask
  task t_regs;
    bus(reg0, 0, 3'h0, 4'hf, 32'hffffffff);
    check("user error", er, 1);
    bus(reg0, 1, 3'h4, 4'hf, 0);
    check("unchanged", rd, 32'h1f033f02);
    bus(reg0 | 32'h4, 0, 3'h4, 4'hf, 32'hffffffff);
    check("no error", er, 0);
    bus(reg0 | 32'h4, 1, 3'h4, 4'hf, 0);
    check("masked", rd, 32'hff03ff03);
    $display("test registers done");
  endtask
  task t_waits;
    for (int ws = 0; ws < 8; ws++) begin
      cfg(2, 16'h3003 | (ws << 8));
      bus(32'hff000000, 1, 3'h4, 4'hf, 0);
      check("read waits", nc, ws + 2);
      check("mirror sel", sel, 4'h4);
      check("read data", rd, 32'h0000ffff);
      bus(32'hff000000, 0, 3'h4, 4'hf, 0);
      check("write waits", nc, ws + 3);
    end
    $display("test waits done");
  endtask
  task t_guard;
    ack_delay <= 4'h2;
    cfg(3, 16'hc003);
    bus(32'h81800000, 1, 3'h0, 4'hf, 0);
    check("user sel", sel, 4'h0);
    check("user end", nc, 3);
    bus(32'h81800000, 0, 3'h4, 4'hf, 0);
    check("ro sel", sel, 4'h0);
    bus(32'h81800000, 1, 3'h4, 4'hf, 0);
    check("sup sel", sel, 4'h8);
    check("sup waits", nc, 3);
    cfg(3, 16'h2001);
    bus(32'h81800000, 1, 3'h4, 4'hf, 0);
    check("ext ack", nc, 3);
    $display("test guard done");
  endtask
  task t_lanes;
    cfg(2, 16'h2803);
    bus(32'h81000000, 1, 3'h4, 4'hf, 0);
    check("we read", lane, 4'h0);
    bus(32'h81000000, 0, 3'h4, 4'hf, 0);
    check("we write", lane, 4'hf);
    cfg(3, 16'h2002);
    bus(32'h81800000, 1, 3'h4, 4'hf, 0);
    check("off lanes", lane, 4'hf);
    check("off sel", sel, 4'h0);
    $display("test lanes done");
  endtask
  task t_split;
    ack_delay <= 4'h0;
    cfg(1, 16'h0003);
    bus(32'h80800010, 1, 3'h4, 4'hf, 0);
    check("split data", rd, 32'h00100012);
    check("split sel", sel, 4'h2);
    bus(32'h80800010, 0, 3'h4, 4'hf, 32'h12345678);
    check("split wdata", ext_wdata, 32'h56780000);
    check("split addr", ext_addr, 32'h80800012);
    check("split dir", ext_read, 0);
    check("split lanes", lane, 4'hc);
    $display("test split done");
  endtask
  task t_early;
    ack_delay <= 4'h3;
    cfg(2, 16'h2703);
    bus(32'h81000000, 1, 3'h4, 4'hf, 0);
    check("early ack", nc, 4);
    err_mode <= 1;
    bus(32'h81000000, 1, 3'h4, 4'hf, 0);
    check("early err", er, 1);
    check("err time", nc, 4);
    err_mode <= 0;
    $display("test early done");
  endtask
  // ==========================================================
  // Main sequence and hang limit
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1;
    t_reset;
    t_regs;
    t_waits;
    t_guard;
    t_lanes;
    t_split;
    t_early;
    stop_test;
  end
endmodule // async_chip_select_unit_test
